/* hw/pcs_consts.svh */
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define PCS_OFF_NUM_PLL      12'h008
`define PCS_OFF_NUM_LANE     12'h00c
`define PCS_OFF_PLL_SEL      12'h020
`define PCS_OFF_LANE_SEL     12'h024
`define PCS_OFF_RX_MASTER    12'h028
`define PCS_OFF_TX_MASTER    12'h02c
`define PCS_OFF_RX_WIDE      12'h030
`define PCS_OFF_TX_WIDE      12'h034
`define PCS_OFF_PLL_STAT     12'h038
`define PCS_OFF_RX_RATE      12'h040
`define PCS_OFF_RX_REFCLK    12'h044
`define PCS_OFF_RX_MULT      12'h048
`define PCS_OFF_RX_PLL       12'h04c
`define PCS_OFF_TX_RATE      12'h050
`define PCS_OFF_TX_REFCLK    12'h054
`define PCS_OFF_TX_MULT      12'h058
`define PCS_OFF_TX_PLL       12'h05c
`define PCS_OFF_SW_CAP       12'h060
`define PCS_OFF_RX_INSERTION_LOSS     12'h064
`define PCS_OFF_EQ           12'h068
`define PCS_OFF_MIN_RATE     12'h06c
`define PCS_OFF_MAX_RATE     12'h070
`define PCS_OFF_MGMT_CLK     12'h074

// ==========================================================================
// field widths and the multiplier scale
`define PCS_PLL_SEL_W        2
`define PCS_LANE_SEL_W       4
`define PCS_STAT_W           5
`define PCS_MULT_SCALE       64'd1000

// ==========================================================================
// reset values and bus answers
`define PCS_PLL_SEL_RST      2'h0
`define PCS_LANE_SEL_RST     4'h0
`define PCS_RESP_OKAY        2'h0
`define PCS_RESP_SLVERR      2'h2

`endif

/* hw/pcs_pkg.sv */
package pcs_pkg;

  // ========================================================================
  // synchronised status, bit order matches the pll status register 4..0
  typedef struct packed {
    logic txRst;
    logic rxRst;
    logic chanUnlock;
    logic priUnlock;
    logic secUnlock;
  } pcs_stat_t;

  // ========================================================================
  // whole state of the register bank
  typedef struct packed {
    pcs_stat_t   s1;
    pcs_stat_t   s2;
    pcs_stat_t   s3;
    pcs_stat_t   filt;
    logic [1:0]  pllSel;
    logic [3:0]  laneSel;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcs_state_t;

endpackage : pcs_pkg

/* hw/pcs_regs.sv */
`timescale 1ns/1ns
`include "pcs_consts.svh"

module pcs_regs #(
  parameter int          NUM_LANES     = 4,
  parameter int          NUM_PLL       = 1,
  parameter bit          HAS_SECONDARY = 1'b1,
  parameter logic [3:0]  RX_MASTER     = 4'h0,
  parameter logic [3:0]  TX_MASTER     = 4'h0,
  parameter bit          RX_WIDE       = 1'b0,
  parameter bit          TX_WIDE       = 1'b0,
  parameter logic [31:0] RX_RATE_KHZ   = 32'h0098_9680,
  parameter logic [31:0] RX_REFCLK_KHZ = 32'h0002_625a,
  parameter logic [1:0]  RX_PLL        = 2'h3,
  parameter logic [31:0] TX_RATE_KHZ   = 32'h0098_9680,
  parameter logic [31:0] TX_REFCLK_KHZ = 32'h0002_625a,
  parameter logic [1:0]  TX_PLL        = 2'h3,
  parameter logic [1:0]  SWITCH_CAP    = 2'h0,
  parameter logic [31:0] RX_INSERTION_LOSS      = 32'h0000_2ee0,
  parameter logic [1:0]  EQ_CHOICE     = 2'h0,
  parameter logic [31:0] MIN_RATE_KHZ  = 32'h001e_8480,
  parameter logic [31:0] MAX_RATE_KHZ  = 32'h00bb_8020,
  parameter logic [31:0] MGMT_CLK_KHZ  = 32'h0001_86a0
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output      logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output      logic                 s_axi_wready,
  output      logic [1:0]           s_axi_bresp,
  output      logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output      logic                 s_axi_arready,
  output      logic [31:0]          s_axi_rdata,
  output      logic [1:0]           s_axi_rresp,
  output      logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 txRstBusy,
  input  wire logic                 rxRstBusy,
  input  wire logic [NUM_LANES-1:0] chanPllLock,
  input  wire logic [NUM_PLL-1:0]   priPllLock,
  input  wire logic [NUM_PLL-1:0]   secPllLock,
  output      logic [1:0]           pllSelect,
  output      logic [3:0]           laneSelect
);

  // ========================================================================
  // generated constants
  localparam logic [63:0] RX_MULT64 =
    64'(RX_RATE_KHZ) * `PCS_MULT_SCALE / 64'(RX_REFCLK_KHZ);
  localparam logic [63:0] TX_MULT64 =
    64'(TX_RATE_KHZ) * `PCS_MULT_SCALE / 64'(TX_REFCLK_KHZ);
  localparam logic [31:0] RX_MULT   = RX_MULT64[31:0];
  localparam logic [31:0] TX_MULT   = TX_MULT64[31:0];
  localparam logic [31:0] PLL_COUNT = 32'(NUM_PLL);
  localparam logic [31:0] LANE_COUNT = 32'(NUM_LANES);

  // selector widths limit what the bank can address
  generate
    if (NUM_LANES < 1 || NUM_LANES > 16) begin : g_bad_lanes
      $error("NUM_LANES must be 1 to 16");
    end
    if (NUM_PLL < 1 || NUM_PLL > 4) begin : g_bad_pll
      $error("NUM_PLL must be 1 to 4");
    end
    if (RX_REFCLK_KHZ == 32'h0 || TX_REFCLK_KHZ == 32'h0) begin : g_bad_ref
      $error("reference clocks must be nonzero");
    end
  endgenerate

  // ========================================================================
  // address decode helpers
  function automatic logic isMapped(input logic [11:0] addr);
    logic [11:0] a;
    a = {addr[11:2], 2'b00};
    case (a)
      `PCS_OFF_NUM_PLL, `PCS_OFF_NUM_LANE, `PCS_OFF_PLL_SEL,
      `PCS_OFF_LANE_SEL, `PCS_OFF_RX_MASTER, `PCS_OFF_TX_MASTER,
      `PCS_OFF_RX_WIDE, `PCS_OFF_TX_WIDE, `PCS_OFF_PLL_STAT,
      `PCS_OFF_RX_RATE, `PCS_OFF_RX_REFCLK, `PCS_OFF_RX_MULT,
      `PCS_OFF_RX_PLL, `PCS_OFF_TX_RATE, `PCS_OFF_TX_REFCLK,
      `PCS_OFF_TX_MULT, `PCS_OFF_TX_PLL, `PCS_OFF_SW_CAP,
      `PCS_OFF_RX_INSERTION_LOSS, `PCS_OFF_EQ, `PCS_OFF_MIN_RATE,
      `PCS_OFF_MAX_RATE, `PCS_OFF_MGMT_CLK: isMapped = 1'b1;
      default:                              isMapped = 1'b0;
    endcase
  endfunction : isMapped

  // read mux; reserved bits are zero by construction
  function automatic logic [31:0] readMux(input logic [11:0] addr,
                                          input pcs_pkg::pcs_state_t s);
    logic [11:0] a;
    a = {addr[11:2], 2'b00};
    readMux = 32'h0;
    case (a)
      `PCS_OFF_NUM_PLL:   readMux = PLL_COUNT;
      `PCS_OFF_NUM_LANE:  readMux = LANE_COUNT;
      `PCS_OFF_PLL_SEL:   readMux = {30'h0, s.pllSel};
      `PCS_OFF_LANE_SEL:  readMux = {28'h0, s.laneSel};
      `PCS_OFF_RX_MASTER: readMux = {28'h0, RX_MASTER};
      `PCS_OFF_TX_MASTER: readMux = {28'h0, TX_MASTER};
      `PCS_OFF_RX_WIDE:   readMux = {31'h0, RX_WIDE};
      `PCS_OFF_TX_WIDE:   readMux = {31'h0, TX_WIDE};
      `PCS_OFF_PLL_STAT:  readMux = {27'h0, s.filt};
      `PCS_OFF_RX_RATE:   readMux = RX_RATE_KHZ;
      `PCS_OFF_RX_REFCLK: readMux = RX_REFCLK_KHZ;
      `PCS_OFF_RX_MULT:   readMux = RX_MULT;
      `PCS_OFF_RX_PLL:    readMux = {30'h0, RX_PLL};
      `PCS_OFF_TX_RATE:   readMux = TX_RATE_KHZ;
      `PCS_OFF_TX_REFCLK: readMux = TX_REFCLK_KHZ;
      `PCS_OFF_TX_MULT:   readMux = TX_MULT;
      `PCS_OFF_TX_PLL:    readMux = {30'h0, TX_PLL};
      `PCS_OFF_SW_CAP:    readMux = {30'h0, SWITCH_CAP};
      `PCS_OFF_RX_INSERTION_LOSS:  readMux = RX_INSERTION_LOSS;
      `PCS_OFF_EQ:        readMux = {30'h0, EQ_CHOICE};
      `PCS_OFF_MIN_RATE:  readMux = MIN_RATE_KHZ;
      `PCS_OFF_MAX_RATE:  readMux = MAX_RATE_KHZ;
      `PCS_OFF_MGMT_CLK:  readMux = MGMT_CLK_KHZ;
      default:            readMux = 32'h0;
    endcase
  endfunction : readMux

  // ========================================================================
  // raw status gathering
  pcs_pkg::pcs_state_t st_ff;
  pcs_pkg::pcs_state_t nxt_st;
  pcs_pkg::pcs_stat_t  rawStat;
  logic                wrTake;
  logic                rdTake;
  logic [11:0]         wrAddr;
  logic [11:0]         rdAddr;

  // lock vectors are reduced before the synchroniser; a glitch in the
  // reduction is absorbed by the two-stage agreement filter below
  always_comb begin
    rawStat.txRst      = txRstBusy;
    rawStat.rxRst      = rxRstBusy;
    rawStat.chanUnlock = ~&chanPllLock;
    rawStat.priUnlock  = ~&priPllLock;
    rawStat.secUnlock  = HAS_SECONDARY ? ~&secPllLock : 1'b0;
  end

  // ========================================================================
  // bus handshakes: one write and one read in flight at a time
  assign wrTake        = s_axi_awvalid && s_axi_wvalid && !st_ff.bvalid;
  assign rdTake        = s_axi_arvalid && !st_ff.rvalid;
  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign s_axi_arready = !st_ff.rvalid;
  assign wrAddr        = {s_axi_awaddr[11:2], 2'b00};
  assign rdAddr        = {s_axi_araddr[11:2], 2'b00};

  // ========================================================================
  // next state
  always_comb begin
    nxt_st    = st_ff;
    // three-stage synchroniser, s1 feeds only s2
    nxt_st.s1 = rawStat;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // a bit only moves once stages two and three agree
    nxt_st.filt = pcs_pkg::pcs_stat_t'(
      ((st_ff.s2 ~^ st_ff.s3) & st_ff.s3) |
      ((st_ff.s2 ^ st_ff.s3) & st_ff.filt));
    // writes: only the two selectors take data, all else is dropped
    if (wrTake) begin
      if (s_axi_wstrb[0] && wrAddr == `PCS_OFF_PLL_SEL) begin
        nxt_st.pllSel = s_axi_wdata[`PCS_PLL_SEL_W-1:0];
      end
      if (s_axi_wstrb[0] && wrAddr == `PCS_OFF_LANE_SEL) begin
        nxt_st.laneSel = s_axi_wdata[`PCS_LANE_SEL_W-1:0];
      end
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = isMapped(s_axi_awaddr) ? `PCS_RESP_OKAY
                                              : `PCS_RESP_SLVERR;
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // reads: data captured at acceptance, held until taken
    if (rdTake) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = readMux(s_axi_araddr, st_ff);
      nxt_st.rresp  = isMapped(s_axi_araddr) ? `PCS_RESP_OKAY
                                              : `PCS_RESP_SLVERR;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff         <= '0;
      st_ff.pllSel  <= `PCS_PLL_SEL_RST;
      st_ff.laneSel <= `PCS_LANE_SEL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp  = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata  = st_ff.rdata;
  assign s_axi_rresp  = st_ff.rresp;
  assign pllSelect    = st_ff.pllSel;
  assign laneSelect   = st_ff.laneSel;

  // ========================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_pll_sel_write: assert property (
    wrTake && s_axi_wstrb[0] && wrAddr == `PCS_OFF_PLL_SEL
    |=> pllSelect == $past(s_axi_wdata[1:0]))
    else $error("pll selector did not take write");

  a_lane_sel_write: assert property (
    wrTake && s_axi_wstrb[0] && wrAddr == `PCS_OFF_LANE_SEL
    |=> laneSelect == $past(s_axi_wdata[3:0]))
    else $error("lane selector did not take write");

  a_ro_write_ignored: assert property (
    wrTake && wrAddr != `PCS_OFF_PLL_SEL && wrAddr != `PCS_OFF_LANE_SEL
    |=> $stable(pllSelect) && $stable(laneSelect))
    else $error("write to read-only register changed a selector");

  a_master_read: assert property (
    rdTake && {s_axi_araddr[11:2], 2'b00} == `PCS_OFF_RX_MASTER
    |=> s_axi_rvalid && s_axi_rdata == {28'h0, RX_MASTER})
    else $error("receive master lane read wrong");

  a_wide_read: assert property (
    rdTake && {s_axi_araddr[11:2], 2'b00} == `PCS_OFF_TX_WIDE
    |=> s_axi_rdata == {31'h0, TX_WIDE})
    else $error("transmit width read wrong");

  a_stat_read: assert property (
    rdTake && {s_axi_araddr[11:2], 2'b00} == `PCS_OFF_PLL_STAT
    |=> s_axi_rdata == {27'h0, $past(st_ff.filt)})
    else $error("pll status read does not match state");

  a_txrst_sync: assert property (
    txRstBusy [*5] |-> st_ff.filt.txRst)
    else $error("transmit reset not seen after five cycles");

  a_unlock_sync: assert property (
    (!priPllLock[0]) [*5] |-> st_ff.filt.priUnlock)
    else $error("primary pll unlock not reported");

  a_no_secondary: assert property (
    (!(&secPllLock)) [*5] |-> st_ff.filt.secUnlock == HAS_SECONDARY)
    else $error("secondary pll unlock reported wrongly");

  a_max_rate_read: assert property (
    rdTake && {s_axi_araddr[11:2], 2'b00} == `PCS_OFF_MAX_RATE
    |=> s_axi_rdata == MAX_RATE_KHZ)
    else $error("highest rate read wrong");

  a_mult_read: assert property (
    rdTake && {s_axi_araddr[11:2], 2'b00} == `PCS_OFF_RX_MULT
    |=> s_axi_rdata == RX_MULT64[31:0])
    else $error("receive multiplier read wrong");

  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  a_unmapped_err: assert property (
    rdTake && !isMapped(s_axi_araddr)
    |=> s_axi_rresp == `PCS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  a_tx_master_read: assert property (
    rdTake && rdAddr == `PCS_OFF_TX_MASTER
    |=> s_axi_rdata == {28'h0, TX_MASTER})
    else $error("transmit master lane read wrong");

  a_rx_wide_read: assert property (
    rdTake && rdAddr == `PCS_OFF_RX_WIDE
    |=> s_axi_rdata == {31'h0, RX_WIDE})
    else $error("receive width read wrong");

  a_rate_read: assert property (
    rdTake && rdAddr == `PCS_OFF_TX_RATE
    |=> s_axi_rdata == TX_RATE_KHZ)
    else $error("transmit default rate read wrong");

  a_refclk_read: assert property (
    rdTake && rdAddr == `PCS_OFF_RX_REFCLK
    |=> s_axi_rdata == RX_REFCLK_KHZ)
    else $error("receive reference clock read wrong");

  a_pll_choice_read: assert property (
    rdTake && rdAddr == `PCS_OFF_RX_PLL
    |=> s_axi_rdata == {30'h0, RX_PLL})
    else $error("receive pll choice read wrong");

  a_switch_cap_read: assert property (
    rdTake && rdAddr == `PCS_OFF_SW_CAP
    |=> s_axi_rdata == {30'h0, SWITCH_CAP})
    else $error("switching capability read wrong");

  a_loss_read: assert property (
    rdTake && rdAddr == `PCS_OFF_RX_INSERTION_LOSS
    |=> s_axi_rdata == RX_INSERTION_LOSS)
    else $error("insertion loss read wrong");

  a_eq_read: assert property (
    rdTake && rdAddr == `PCS_OFF_EQ
    |=> s_axi_rdata == {30'h0, EQ_CHOICE})
    else $error("equaliser choice read wrong");

  a_min_rate_read: assert property (
    rdTake && rdAddr == `PCS_OFF_MIN_RATE
    |=> s_axi_rdata == MIN_RATE_KHZ)
    else $error("lowest rate read wrong");

  a_mgmt_clk_read: assert property (
    rdTake && rdAddr == `PCS_OFF_MGMT_CLK
    |=> s_axi_rdata == MGMT_CLK_KHZ)
    else $error("management clock read wrong");

  a_pll_count_read: assert property (
    rdTake && rdAddr == `PCS_OFF_NUM_PLL
    |=> s_axi_rdata == PLL_COUNT)
    else $error("shared pll count read wrong");

  a_rxrst_sync: assert property (
    rxRstBusy [*5] |-> st_ff.filt.rxRst)
    else $error("receive reset not seen after five cycles");

  a_chan_unlock: assert property (
    (!(&chanPllLock)) [*5] |-> st_ff.filt.chanUnlock)
    else $error("channel pll unlock not reported");

  a_strobe_off: assert property (
    wrTake && !s_axi_wstrb[0]
    |=> $stable(pllSelect) && $stable(laneSelect))
    else $error("write with strobe low changed a selector");

  // the write answer must not vanish while the master stalls it
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");

endmodule : pcs_regs

/* verification/tb_top.sv */
`timescale 1ns/1ns
`include "pcs_consts.svh"

// one compare: counts it, reports a mismatch on the spot
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_top;

  // ========================================================================
  // generated constants; some small fields share a value (RX_M, RX_P and EQ_C are all 2)
  localparam logic [3:0]  RX_M   = 4'h2;
  localparam logic [3:0]  TX_M   = 4'h1;
  localparam logic [31:0] RX_R   = 32'h0098_9680;
  localparam logic [31:0] RX_C   = 32'h0002_625a;
  localparam logic [31:0] TX_R   = 32'h0060_1a70;
  localparam logic [31:0] TX_C   = 32'h0001_e848;
  localparam logic [1:0]  RX_P   = 2'h2;
  localparam logic [1:0]  TX_P   = 2'h0;
  localparam logic [31:0] LOSS   = 32'h0000_2ee0;
  localparam logic [31:0] MIN_R  = 32'h001e_8480;
  localparam logic [31:0] MAX_R  = 32'h00bb_8020;
  localparam logic [31:0] MGMT   = 32'h0001_86a0;
  // truncating division, as the bank reports it
  localparam logic [31:0] RX_X   = 32'((64'(RX_R) * 64'd1000) / 64'(RX_C));
  localparam logic [31:0] TX_X   = 32'((64'(TX_R) * 64'd1000) / 64'(TX_C));
  localparam int          LANES  = 4;
  localparam int          PLLS   = 2;
  localparam bit          SEC_ON = 1'b1;
  localparam bit          RX_WD  = 1'b1;
  localparam bit          TX_WD  = 1'b0;
  localparam logic [1:0]  SW_C   = 2'h1;
  localparam logic [1:0]  EQ_C   = 2'h2;
  localparam logic [1:0]  RESP_OK = `PCS_RESP_OKAY;

  logic        ref_clk;
  logic        reset;
  logic [11:0] awAddr;
  logic        awValid;
  logic        awReady;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wValid;
  logic        wReady;
  logic [1:0]  bResp;
  logic        bValid;
  logic        bReady;
  logic [11:0] arAddr;
  logic        arValid;
  logic        arReady;
  logic [31:0] rData;
  logic [1:0]  rResp;
  logic        rValid;
  logic        rReady;
  logic        txBusy;
  logic        rxBusy;
  logic [3:0]  chanLock;
  logic [1:0]  priLock;
  logic [1:0]  secLock;
  logic [1:0]  pllSel;
  logic [3:0]  laneSel;
  logic [31:0] stat;
  int          miscompares;
  int          comparisons;

  pcs_regs #(.NUM_LANES(LANES), .NUM_PLL(PLLS), .HAS_SECONDARY(SEC_ON),
    .RX_MASTER(RX_M), .TX_MASTER(TX_M), .RX_WIDE(RX_WD), .TX_WIDE(TX_WD),
    .RX_RATE_KHZ(RX_R), .RX_REFCLK_KHZ(RX_C), .RX_PLL(RX_P),
    .TX_RATE_KHZ(TX_R), .TX_REFCLK_KHZ(TX_C), .TX_PLL(TX_P),
    .SWITCH_CAP(SW_C), .RX_INSERTION_LOSS(LOSS), .EQ_CHOICE(EQ_C),
    .MIN_RATE_KHZ(MIN_R), .MAX_RATE_KHZ(MAX_R), .MGMT_CLK_KHZ(MGMT)
  ) uut (
    .ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .txRstBusy(txBusy), .rxRstBusy(rxBusy),
    .chanPllLock(chanLock), .priPllLock(priLock), .secPllLock(secLock),
    .pllSelect(pllSel), .laneSelect(laneSel)
  );

  // ========================================================================
  // clock, 10 ns period
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // verdict and end of run, also reached by a timed-out wait
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // handshake level picked by number, so the wait needs no ref argument
  function automatic logic hsLevel(input int which);
    case (which)
      0:       hsLevel = awReady;
      1:       hsLevel = arReady;
      2:       hsLevel = bValid;
      default: hsLevel = rValid;
    endcase
  endfunction : hsLevel

  // bounded wait at falling edges, where handshake outputs are settled
  task automatic wait_hi(input int which);
    int n;
    n = 0;
    while (hsLevel(which) !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_hi

  // one write; address and data stay up until the accepting edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] st, input logic [1:0] er);
    awAddr  = a;
    wData   = d;
    wStrb   = st;
    awValid = 1'b1;
    wValid  = 1'b1;
    @(negedge ref_clk);
    wait_hi(0);
    @(posedge ref_clk);
    #1;
    awValid = 1'b0;
    wValid  = 1'b0;
    wait_hi(2);
    `CHK("bresp", er, bResp)
    @(posedge ref_clk);
    #1;
  endtask : wr

  // one read, compared with the expected word and answer code
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    arAddr  = a;
    arValid = 1'b1;
    @(negedge ref_clk);
    wait_hi(1);
    @(posedge ref_clk);
    #1;
    arValid = 1'b0;
    wait_hi(3);
    `CHK("rdata", e, rData)
    `CHK("rresp", er, rResp)
    @(posedge ref_clk);
    #1;
  endtask : rd

  // constant register: a write of all ones is dropped, then the value reads
  task automatic ro_chk(input logic [11:0] a, input logic [31:0] e);
    wr(a, 32'hffff_ffff, 4'hf, RESP_OK);
    rd(a, e, RESP_OK);
  endtask : ro_chk

  // ========================================================================
  // main sequence
  initial begin
    {awAddr, awValid, wData, wStrb, wValid, arAddr, arValid} = '0;
    {txBusy, rxBusy} = 2'h0;
    {chanLock, priLock, secLock} = 8'hff;
    bReady = 1'b1;
    rReady = 1'b1;
    miscompares = 0;
    comparisons = 0;
    reset = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    // selectors: reserved bits dropped, strobe low leaves them alone
    rd(`PCS_OFF_PLL_SEL, 32'h0, `PCS_RESP_OKAY);
    wr(`PCS_OFF_PLL_SEL, 32'hffff_fffe, 4'hf, `PCS_RESP_OKAY);
    rd(`PCS_OFF_PLL_SEL, 32'h2, `PCS_RESP_OKAY);
    `CHK("pllSelect", 2'h2, pllSel)
    wr(`PCS_OFF_LANE_SEL, 32'h0000_00a9, 4'hf, `PCS_RESP_OKAY);
    wr(`PCS_OFF_LANE_SEL, 32'h0000_0003, 4'h0, `PCS_RESP_OKAY);
    rd(`PCS_OFF_LANE_SEL, 32'h9, `PCS_RESP_OKAY);
    `CHK("laneSelect", 4'h9, laneSel)
    // unmapped place answers with an error and reads zero
    wr(12'h0fc, 32'hffff_ffff, 4'hf, `PCS_RESP_SLVERR);
    rd(12'h0fc, 32'h0, `PCS_RESP_SLVERR);
    // answers stand while ready is low, and new requests wait for them
    bReady = 1'b0;
    rReady = 1'b0;
    wr(`PCS_OFF_PLL_SEL, 32'h0000_0001, 4'hf, `PCS_RESP_OKAY);
    rd(`PCS_OFF_LANE_SEL, 32'h9, `PCS_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("bvalid held", 1'b1, bValid)
    `CHK("rvalid held", 1'b1, rValid)
    `CHK("rdata held", 32'h9, rData)
    `CHK("arready refused", 1'b0, arReady)
    awAddr  = `PCS_OFF_LANE_SEL;
    wData   = 32'h0000_0006;
    wStrb   = 4'hf;
    awValid = 1'b1;
    wValid  = 1'b1;
    @(negedge ref_clk);
    `CHK("awready refused", 1'b0, awReady)
    `CHK("pllSelect", 2'h1, pllSel)
    @(posedge ref_clk);
    #1;
    bReady = 1'b1;
    rReady = 1'b1;
    // the request already standing is taken once the answer is gone
    wr(`PCS_OFF_LANE_SEL, 32'h0000_0006, 4'hf, `PCS_RESP_OKAY);
    rd(`PCS_OFF_LANE_SEL, 32'h6, `PCS_RESP_OKAY);
    `CHK("laneSelect", 4'h6, laneSel)
    // constants ignore writes of all ones and read their generated value
    ro_chk(`PCS_OFF_RX_MASTER, {28'h0, RX_M});
    ro_chk(`PCS_OFF_TX_MASTER, {28'h0, TX_M});
    ro_chk(`PCS_OFF_RX_WIDE, {31'h0, RX_WD});
    ro_chk(`PCS_OFF_TX_WIDE, {31'h0, TX_WD});
    ro_chk(`PCS_OFF_RX_RATE, RX_R);
    ro_chk(`PCS_OFF_TX_RATE, TX_R);
    ro_chk(`PCS_OFF_RX_REFCLK, RX_C);
    ro_chk(`PCS_OFF_TX_REFCLK, TX_C);
    ro_chk(`PCS_OFF_RX_MULT, RX_X);
    ro_chk(`PCS_OFF_TX_MULT, TX_X);
    ro_chk(`PCS_OFF_RX_PLL, {30'h0, RX_P});
    ro_chk(`PCS_OFF_TX_PLL, {30'h0, TX_P});
    ro_chk(`PCS_OFF_SW_CAP, {30'h0, SW_C});
    ro_chk(`PCS_OFF_RX_INSERTION_LOSS, LOSS);
    ro_chk(`PCS_OFF_EQ, {30'h0, EQ_C});
    ro_chk(`PCS_OFF_MIN_RATE, MIN_R);
    ro_chk(`PCS_OFF_MAX_RATE, MAX_R);
    ro_chk(`PCS_OFF_MGMT_CLK, MGMT);
    ro_chk(`PCS_OFF_NUM_PLL, 32'(PLLS));
    ro_chk(`PCS_OFF_NUM_LANE, 32'(LANES));
    // status: one cause at a time, one lock bit missing out of several
    for (int i = 0; i <= 5; i++) begin
      stat     = (i < 5) ? (32'h1 << i) : 32'h0;
      txBusy   = stat[4];
      rxBusy   = stat[3];
      chanLock = stat[2] ? 4'hb : 4'hf;
      priLock  = stat[1] ? 2'h2 : 2'h3;
      secLock  = stat[0] ? 2'h1 : 2'h3;
      // let the synchroniser settle before reading
      repeat (6) @(posedge ref_clk);
      #1;
      rd(`PCS_OFF_PLL_STAT, stat, RESP_OK);
    end
    // a reset in mid-run returns both selectors to their reset value
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    `CHK("pllSelect reset", `PCS_PLL_SEL_RST, pllSel)
    `CHK("laneSelect reset", `PCS_LANE_SEL_RST, laneSel)
    rd(`PCS_OFF_PLL_SEL, 32'h0, `PCS_RESP_OKAY);
    end_sim();
  end

endmodule : tb_top
